// ==== core/nsc_host.v ====
// host controller driving an nvsram through its strobes, address, data and busy pins
`timescale 1ns/1ps
`default_nettype none
`include "nsc_defines.vh"
module nsc_host #(
    parameter integer ADDR_W      = 15,
    parameter integer DATA_W      = 8,
    parameter integer DELAY_CYC   = (`NSC_DELAY_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS,
    parameter integer STORE_CYC   = (`NSC_STORE_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS,
    parameter integer RECALL_CYC  = (`NSC_RECALL_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS
)(
    input  wire              MCLK,
    input  wire              RST_N,
    input  wire              CMD_VALID,
    input  wire [2:0]        CMD_OP,
    input  wire [ADDR_W-1:0] CMD_ADDR,
    input  wire [DATA_W-1:0] CMD_WDATA,
    input  wire              SUPPLY_OK,
    output reg               CMD_READY,
    output reg               RSP_VALID,
    output reg  [DATA_W-1:0] RSP_RDATA,
    output reg  [ADDR_W-1:0] MEM_ADDR,
    output reg               MEM_CE_N,
    output reg               MEM_OE_N,
    output reg               MEM_WE_N,
    input  wire [DATA_W-1:0] MEM_DQ_IN,
    output reg  [DATA_W-1:0] MEM_DQ_OUT,
    output reg               MEM_DQ_OE,
    input  wire              MEM_BUSY_N_IN,
    output reg               MEM_BUSY_N_OUT,
    output reg               MEM_BUSY_N_OE,
    output reg               BUSY
);
    // cycle counts derived from access and write-turnoff times
    localparam integer ACC_I   = (`NSC_ACCESS_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS;
    localparam integer HZ_I    = (`NSC_HZWE_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS;
    localparam [3:0]  ACC_CYC = ACC_I[3:0];
    localparam [3:0]  HZ_CYC  = HZ_I[3:0];
    localparam [31:0] DLY_C   = DELAY_CYC;
    localparam [31:0] STO_C   = STORE_CYC;
    localparam [31:0] REC_C   = RECALL_CYC;

    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_READ  = 3'h1;
    localparam [2:0] S_WRITE = 3'h2;
    localparam [2:0] S_GAP   = 3'h3;
    localparam [2:0] S_WAIT  = 3'h4;
    localparam [2:0] S_HWREQ = 3'h5;
    localparam [2:0] S_HWREL = 3'h6;

    // sequence address lookup; step 5 depends on the operation
    function [13:0] seq_addr;
        input [2:0] step;
        input [2:0] op;
        begin
            case (step)
                3'h0: seq_addr = `NSC_SEQ_A1;
                3'h1: seq_addr = `NSC_SEQ_A2;
                3'h2: seq_addr = `NSC_SEQ_A3;
                3'h3: seq_addr = `NSC_SEQ_A4;
                3'h4: seq_addr = `NSC_SEQ_A5;
                default:
                    case (op)
                        `NSC_OP_SW_STORE: seq_addr = `NSC_SEQ_STORE;
                        `NSC_OP_SW_RECALL: seq_addr = `NSC_SEQ_RECALL;
                        `NSC_OP_AS_OFF: seq_addr = `NSC_SEQ_AS_OFF;
                        default: seq_addr = `NSC_SEQ_AS_ON;
                    endcase
            endcase
        end
    endfunction

    // ============================================================
    // pin synchronisers
    // ============================================================
    reg [DATA_W-1:0] dq_s1_q;
    reg [DATA_W-1:0] dq_s2_q;
    reg              busy_s1_q;
    reg              busy_s2_q;
    reg              sup_s1_q;
    reg              sup_s2_q;

    // two flops before any use; supply level and busy come off-chip
    always @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            dq_s1_q   <= {DATA_W{1'b0}};
            dq_s2_q   <= {DATA_W{1'b0}};
            busy_s1_q <= 1'b1;
            busy_s2_q <= 1'b1;
            sup_s1_q  <= 1'b0;
            sup_s2_q  <= 1'b0;
        end
        else
        begin
            dq_s1_q   <= MEM_DQ_IN;
            dq_s2_q   <= dq_s1_q;
            busy_s1_q <= MEM_BUSY_N_IN;
            busy_s2_q <= busy_s1_q;
            sup_s1_q  <= SUPPLY_OK;
            sup_s2_q  <= sup_s1_q;
        end
    end

    // ============================================================
    // cycle engine
    // ============================================================
    reg [2:0]  state_q;
    reg [2:0]  op_q;
    reg [2:0]  step_q;
    reg [31:0] cnt_q;

    // a counted wait that may be stretched while the device holds busy low
    always @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_q        <= S_WAIT;
            cnt_q          <= REC_C;      // power-up recall window
            op_q           <= `NSC_OP_READ;
            step_q         <= 3'h0;
            CMD_READY      <= 1'b0;
            RSP_VALID      <= 1'b0;
            RSP_RDATA      <= {DATA_W{1'b0}};
            MEM_ADDR       <= {ADDR_W{1'b0}};
            MEM_CE_N       <= 1'b1;
            MEM_OE_N       <= 1'b1;
            MEM_WE_N       <= 1'b1;
            MEM_DQ_OUT     <= {DATA_W{1'b0}};
            MEM_DQ_OE      <= 1'b0;
            MEM_BUSY_N_OUT <= 1'b0;
            MEM_BUSY_N_OE  <= 1'b0;
            BUSY           <= 1'b1;
        end
        else
        begin
            RSP_VALID  <= 1'b0;
            if (!sup_s2_q)
            begin
                // low supply: park the bus, wait out recall once it returns
                state_q   <= S_WAIT;
                cnt_q     <= REC_C;
                MEM_CE_N  <= 1'b1;
                MEM_OE_N  <= 1'b1;
                MEM_WE_N  <= 1'b1;
                MEM_DQ_OE <= 1'b0;
                MEM_BUSY_N_OE <= 1'b0;
                CMD_READY <= 1'b0;
                BUSY      <= 1'b1;
            end
            else
            case (state_q)
                S_IDLE:
                begin
                    BUSY <= 1'b0;
                    if (!busy_s2_q)
                    begin
                        // device-side store in progress: hold off
                        CMD_READY <= 1'b0;
                        BUSY      <= 1'b1;
                    end
                    else if (CMD_VALID && CMD_READY)
                    begin
                        CMD_READY <= 1'b0;
                        BUSY      <= 1'b1;
                        op_q      <= CMD_OP;
                        step_q    <= 3'h0;
                        cnt_q     <= {28'h0, ACC_CYC};
                        case (CMD_OP)
                            `NSC_OP_READ:
                            begin
                                MEM_ADDR <= CMD_ADDR;
                                MEM_CE_N <= 1'b0;
                                MEM_OE_N <= 1'b0;
                                state_q  <= S_READ;
                            end
                            `NSC_OP_WRITE:
                            begin
                                // output enable stays high to avoid contention
                                MEM_ADDR   <= CMD_ADDR;
                                MEM_DQ_OUT <= CMD_WDATA;
                                MEM_DQ_OE  <= 1'b1;
                                MEM_CE_N   <= 1'b0;
                                MEM_WE_N   <= 1'b0;
                                state_q    <= S_WRITE;
                            end
                            `NSC_OP_HW_STORE:
                            begin
                                MEM_BUSY_N_OE <= 1'b1;
                                cnt_q         <= DLY_C;
                                state_q       <= S_HWREQ;
                            end
                            default:
                            begin
                                // software sequence, read cycles with output off
                                MEM_ADDR <= {1'b0, `NSC_SEQ_A1};
                                MEM_CE_N <= 1'b0;
                                state_q  <= S_READ;
                            end
                        endcase
                    end
                    else
                        CMD_READY <= 1'b1;
                end
                S_READ:
                begin
                    if (cnt_q != 32'h0)
                        cnt_q <= cnt_q - 32'h1;
                    else
                    begin
                        MEM_CE_N <= 1'b1;
                        MEM_OE_N <= 1'b1;
                        if (op_q == `NSC_OP_READ)
                        begin
                            RSP_VALID <= 1'b1;
                            RSP_RDATA <= dq_s2_q;
                            state_q   <= S_GAP;
                        end
                        else if (step_q == 3'h5)
                        begin
                            // transfer runs; chip ignores us until done
                            RSP_VALID <= 1'b1;
                            state_q   <= S_WAIT;
                            cnt_q     <= (op_q == `NSC_OP_SW_STORE) ? STO_C :
                                         (op_q == `NSC_OP_SW_RECALL) ? REC_C : 32'h1;
                        end
                        else
                        begin
                            // back-to-back reads only, no other access between
                            step_q  <= step_q + 3'h1;
                            state_q <= S_GAP;
                        end
                    end
                end
                S_WRITE:
                begin
                    // device may float outputs; we drive data regardless
                    if (cnt_q > {28'h0, HZ_CYC})
                        cnt_q <= cnt_q - 32'h1;
                    else
                    begin
                        MEM_WE_N  <= 1'b1;
                        MEM_CE_N  <= 1'b1;
                        RSP_VALID <= 1'b1;
                        state_q   <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    // strobes rise for a cycle so each access is a fresh edge
                    MEM_DQ_OE <= 1'b0;
                    cnt_q     <= {28'h0, ACC_CYC};
                    if (op_q == `NSC_OP_READ || op_q == `NSC_OP_WRITE)
                        state_q <= S_IDLE;
                    else
                    begin
                        MEM_ADDR <= {1'b0, seq_addr(step_q, op_q)};
                        MEM_CE_N <= 1'b0;
                        state_q  <= S_READ;
                    end
                end
                S_WAIT:
                begin
                    // counted wait; no access until device is free again
                    if (cnt_q != 32'h0)
                        cnt_q <= cnt_q - 32'h1;
                    else if (busy_s2_q)
                        state_q <= S_IDLE;
                end
                S_HWREQ:
                begin
                    // hold request over the delay so the device samples it
                    if (cnt_q != 32'h0)
                        cnt_q <= cnt_q - 32'h1;
                    else
                    begin
                        MEM_BUSY_N_OE <= 1'b0;
                        cnt_q         <= 32'h2;
                        state_q       <= S_HWREL;
                    end
                end
                S_HWREL:
                begin
                    // store may be skipped by the device if nothing was written
                    if (cnt_q != 32'h0)
                        cnt_q <= cnt_q - 32'h1;
                    else
                    begin
                        RSP_VALID <= 1'b1;
                        state_q   <= S_WAIT;
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end
endmodule // nsc_host
`default_nettype wire

// ==== inc/nsc_defines.vh ====
// constants for the nvsram host-side store/recall controller
`ifndef NSC_DEFINES_VH
`define NSC_DEFINES_VH
// software mode sequence addresses (lower 14 address lines)
`define NSC_SEQ_A1        14'h0e38
`define NSC_SEQ_A2        14'h31c7
`define NSC_SEQ_A3        14'h03e0
`define NSC_SEQ_A4        14'h3c1f
`define NSC_SEQ_A5        14'h303f
`define NSC_SEQ_STORE     14'h0fc0
`define NSC_SEQ_RECALL    14'h0c63
`define NSC_SEQ_AS_OFF    14'h03f8
`define NSC_SEQ_AS_ON     14'h07f0
// command codes on CMD_OP
`define NSC_OP_READ       3'h0
`define NSC_OP_WRITE      3'h1
`define NSC_OP_SW_STORE   3'h2
`define NSC_OP_SW_RECALL  3'h3
`define NSC_OP_AS_OFF     3'h4
`define NSC_OP_AS_ON      3'h5
`define NSC_OP_HW_STORE   3'h6
// timing in ns, at 20 ns per clock
`define NSC_CLK_NS        20
`define NSC_ACCESS_NS     45
`define NSC_DELAY_NS      25000
`define NSC_STORE_NS      15000000
`define NSC_RECALL_NS     200000
`define NSC_HZWE_NS       15
`endif

// ==== tb/nsc_host_checker.sv ====
// port assertions for the nvsram host controller
`timescale 1ns/1ps
`default_nettype none
module nsc_host_checker #(
    parameter integer ADDR_W = 15,
    parameter integer DATA_W = 8
)(
    input wire logic              MCLK,
    input wire logic              RST_N,
    input wire logic              CMD_VALID,
    input wire logic [2:0]        CMD_OP,
    input wire logic [ADDR_W-1:0] CMD_ADDR,
    input wire logic [DATA_W-1:0] CMD_WDATA,
    input wire logic              SUPPLY_OK,
    input wire logic              CMD_READY,
    input wire logic              RSP_VALID,
    input wire logic [DATA_W-1:0] RSP_RDATA,
    input wire logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic              MEM_CE_N,
    input wire logic              MEM_OE_N,
    input wire logic              MEM_WE_N,
    input wire logic [DATA_W-1:0] MEM_DQ_IN,
    input wire logic [DATA_W-1:0] MEM_DQ_OUT,
    input wire logic              MEM_DQ_OE,
    input wire logic              MEM_BUSY_N_IN,
    input wire logic              MEM_BUSY_N_OUT,
    input wire logic              MEM_BUSY_N_OE,
    input wire logic              BUSY
);
    // ============================================================
    // strobe and handshake relations
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    oe_we_excl_a: assert property (!MEM_WE_N |-> MEM_OE_N) else $error("output enable low in write");
    wr_ce_a: assert property (!MEM_WE_N |-> !MEM_CE_N) else $error("write without chip enable");
    wr_dq_a: assert property (!MEM_WE_N |-> MEM_DQ_OE) else $error("data not driven in write");
    wr_addr_a: assert property (!MEM_WE_N && !$past(MEM_WE_N) |-> $stable(MEM_ADDR))
        else $error("address moved in write");
    wr_end_a: assert property ($rose(MEM_WE_N) |-> MEM_DQ_OE && $stable(MEM_DQ_OUT))
        else $error("data dropped at write end");
    wr_len_a: assert property ($fell(MEM_WE_N) |-> ##[1:3] MEM_WE_N) else $error("write strobe too long");
    rd_rsp_a: assert property ($fell(MEM_OE_N) |-> ##[3:5] RSP_VALID) else $error("read answer late");
    rsp_pulse_a: assert property (RSP_VALID |=> !RSP_VALID) else $error("answer longer than a cycle");
    supply_refuse_a: assert property (!SUPPLY_OK [*4] |-> !CMD_READY) else $error("ready in low supply");
    busy_pull_a: assert property (MEM_BUSY_N_OE |-> !MEM_BUSY_N_OUT && MEM_WE_N)
        else $error("write while store requested");
    idle_quiet_a: assert property (CMD_READY |-> MEM_CE_N && MEM_WE_N) else $error("access while idle");
    ready_busy_a: assert property (CMD_READY |-> !BUSY) else $error("ready while busy");
endmodule // nsc_host_checker
bind nsc_host nsc_host_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
    .MCLK(MCLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR),
    .CMD_WDATA(CMD_WDATA), .SUPPLY_OK(SUPPLY_OK), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID),
    .RSP_RDATA(RSP_RDATA), .MEM_ADDR(MEM_ADDR), .MEM_CE_N(MEM_CE_N), .MEM_OE_N(MEM_OE_N),
    .MEM_WE_N(MEM_WE_N), .MEM_DQ_IN(MEM_DQ_IN), .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE(MEM_DQ_OE),
    .MEM_BUSY_N_IN(MEM_BUSY_N_IN), .MEM_BUSY_N_OUT(MEM_BUSY_N_OUT), .MEM_BUSY_N_OE(MEM_BUSY_N_OE), .BUSY(BUSY));
`default_nettype wire

// ==== tb/nsc_nvram_model.sv ====
// behavioural nvsram on the far side of the host controller
`timescale 1ns/1ps
`default_nettype none
`include "nsc_defines.vh"
module nsc_nvram_model #(
    parameter int DLY = 4,
    parameter int ST  = 30,
    parameter int RC  = 10
)(
    input  wire logic        clk,
    input  wire logic        sup_ok,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [14:0] addr,
    input  wire logic [7:0]  din,
    input  wire logic        busy_n,
    output logic      [7:0]  dq,
    output logic             busy_drv
);
    logic [7:0]  mem [0:32767];
    logic [7:0]  nv [0:32767];
    logic [7:0]  last_q;
    logic [14:0] wa_q;
    logic        ce_q, wr_q, is_st, dirty = 0, as_en = 1, rc_pend = 1, sup_q = 0, wr_blk = 0;
    int          xfer = 0, hcnt = 0, step = 0, st_cnt = 0;
    logic [13:0] seq [0:4] = '{`NSC_SEQ_A1, `NSC_SEQ_A2, `NSC_SEQ_A3, `NSC_SEQ_A4, `NSC_SEQ_A5};
    wire logic   rd = !ce_n && !oe_n && we_n && busy_n && xfer == 0;
    wire logic   wr = !ce_n && !we_n && busy_n;
    // released bus toggles so a stale byte never reads as valid
    assign dq = rd ? mem[addr] : ~last_q;
    assign busy_drv = xfer > 0 && is_st;
    // ============================================================
    // transfers between the two arrays
    task automatic go(input logic st);
        xfer = st ? ST : RC;
        is_st = st;
        for (int i = 0; i < 32768; i++)
            if (st) nv[i] = mem[i]; else mem[i] = nv[i];
        st_cnt += int'(st);
        dirty = 0;
    endtask
    task automatic seq_step(input logic [13:0] a);
        if (step == 5)
        begin
            step = 0;
            case (a)
                `NSC_SEQ_STORE:  go(1);
                `NSC_SEQ_RECALL: go(0);
                `NSC_SEQ_AS_OFF: as_en = 0;
                `NSC_SEQ_AS_ON:  as_en = 1;
                default: step = int'(a == seq[0]);
            endcase
        end
        else
            step = (a == seq[step]) ? step + 1 : int'(a == seq[0]);
    endtask
    // ============================================================
    // one evaluation per clock, on the falling edge so host samples never race it
    always @(negedge clk)
    begin
        last_q = dq;
        if (xfer > 0)
        begin
            xfer--;
            wr_blk = wr;
        end
        else if (!sup_ok)
        begin
            if (sup_q && as_en && dirty) go(1);
            rc_pend = 1;
        end
        else if (rc_pend)
        begin
            rc_pend = 0;
            go(0);
        end
        else
        begin
            if (wr_q && !wr && !wr_blk) begin mem[wa_q] = din; dirty = 1; step = 0; end
            if (ce_q && !ce_n && we_n) seq_step(addr[13:0]);
            hcnt = busy_n ? 0 : hcnt + 1;
            if (hcnt == DLY && dirty) go(1);
        end
        if (!wr) wr_blk = 0;
        if (wr) wa_q = addr;
        wr_q = wr;
        ce_q = ce_n;
        sup_q = sup_ok;
    end
endmodule // nsc_nvram_model
`default_nettype wire

// ==== tb/nvsram_store_recall_control_tb_top.sv ====
// self-checking bench for the nvsram host controller
`timescale 1ns/1ps
`default_nettype none
`include "nsc_defines.vh"
module nvsram_store_recall_control_tb_top;
    logic        MCLK = 0, RST_N = 0, CMD_VALID = 0, SUPPLY_OK = 1;
    logic [2:0]  CMD_OP = 0;
    logic [14:0] CMD_ADDR = 0;
    logic [7:0]  CMD_WDATA = 0;
    wire logic   CMD_READY, RSP_VALID, MEM_CE_N, MEM_OE_N, MEM_WE_N, MEM_DQ_OE, MEM_BUSY_N_OUT, MEM_BUSY_N_OE, BUSY;
    wire logic   mbusy;
    wire logic [7:0]  RSP_RDATA, MEM_DQ_OUT, mdq;
    wire logic [14:0] MEM_ADDR;
    // pulled up, either party may pull it low
    wire logic   busy_line = !(MEM_BUSY_N_OE && !MEM_BUSY_N_OUT) && !mbusy;
    logic [8:0]  exp_q [$];
    int          error_cnt = 0, checks = 0;
    logic [31:0] seed = 32'h7186bb68;
    nsc_host #(.DELAY_CYC(4), .STORE_CYC(20), .RECALL_CYC(20)) dut (
        .MCLK(MCLK), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR),
        .CMD_WDATA(CMD_WDATA), .SUPPLY_OK(SUPPLY_OK), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID),
        .RSP_RDATA(RSP_RDATA), .MEM_ADDR(MEM_ADDR), .MEM_CE_N(MEM_CE_N), .MEM_OE_N(MEM_OE_N),
        .MEM_WE_N(MEM_WE_N), .MEM_DQ_IN(mdq), .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE(MEM_DQ_OE),
        .MEM_BUSY_N_IN(busy_line), .MEM_BUSY_N_OUT(MEM_BUSY_N_OUT), .MEM_BUSY_N_OE(MEM_BUSY_N_OE), .BUSY(BUSY));
    // model keeps its own timing defaults: request delay 4, store 30, recall 10
    nsc_nvram_model m (
        .clk(MCLK), .sup_ok(SUPPLY_OK), .ce_n(MEM_CE_N), .oe_n(MEM_OE_N), .we_n(MEM_WE_N),
        .addr(MEM_ADDR), .din(MEM_DQ_OUT), .busy_n(busy_line), .dq(mdq), .busy_drv(mbusy));
    always #10 MCLK = ~MCLK;
    // ============================================================
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one request, its note queued, then wait for its answer
    task automatic op(input logic [2:0] o, input logic [14:0] a, input logic [7:0] d, input logic c,
                      input logic [7:0] e);
        int n;
        for (n = 0; n < 3000 && CMD_READY !== 1'b1; n++) @(negedge MCLK);
        @(posedge MCLK);
        CMD_VALID <= 1'b1;
        CMD_OP <= o;
        CMD_ADDR <= a;
        CMD_WDATA <= d;
        exp_q.push_back({c, e});
        // hold the request until an edge finds ready high
        @(posedge MCLK);
        for (n = 0; n < 3000 && CMD_READY !== 1'b1; n++) @(posedge MCLK);
        CMD_VALID <= 1'b0;
        for (n = 0; n < 3000 && exp_q.size() > 0; n++) @(negedge MCLK);
        if (n == 3000) error_cnt++;
    endtask
    // ============================================================
    // answer monitor: oldest note against each answer
    always @(posedge MCLK)
    begin
        logic [8:0] e;
        if (RST_N && RSP_VALID === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0);
            else
            begin
                e = exp_q.pop_front();
                if (e[8]) chk(RSP_RDATA, e[7:0]);
            end
        end
    end
    // ============================================================
    // main sequence
    initial
    begin
        logic [14:0] a;
        logic [7:0]  d0;
        int          s0;
        repeat (4) @(posedge MCLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            a = 15'(xs());
            d0 = 8'(xs());
            op(`NSC_OP_WRITE, a, d0, 0, 0);
            op(`NSC_OP_READ, a, 0, 1, d0);
        end
        $display("test read write done");
        a = 15'h0123;
        d0 = 8'(xs());
        op(`NSC_OP_WRITE, a, d0, 0, 0);
        s0 = m.st_cnt;
        op(`NSC_OP_SW_STORE, 0, 0, 0, 0);
        op(`NSC_OP_SW_STORE, 0, 0, 0, 0);
        chk(m.st_cnt, s0 + 2);
        op(`NSC_OP_WRITE, a, ~d0, 0, 0);
        op(`NSC_OP_SW_RECALL, 0, 0, 0, 0);
        op(`NSC_OP_READ, a, 0, 1, d0);
        $display("test software store recall done");
        // a store request right after a recall finds nothing written
        op(`NSC_OP_HW_STORE, 0, 0, 0, 0);
        chk(m.st_cnt, s0 + 2);
        op(`NSC_OP_WRITE, a, ~d0, 0, 0);
        op(`NSC_OP_HW_STORE, 0, 0, 0, 0);
        chk(m.st_cnt, s0 + 3);
        op(`NSC_OP_AS_OFF, 0, 0, 0, 0);
        chk(m.as_en, 0);
        op(`NSC_OP_AS_ON, 0, 0, 0, 0);
        chk(m.as_en, 1);
        $display("test store control done");
        op(`NSC_OP_WRITE, a, d0, 0, 0);
        @(posedge MCLK);
        SUPPLY_OK <= 1'b0;
        // stay low until the automatic store is over, as a real outage would
        repeat (40) @(negedge MCLK);
        chk(CMD_READY, 0);
        chk(m.st_cnt, s0 + 4);
        @(posedge MCLK);
        SUPPLY_OK <= 1'b1;
        op(`NSC_OP_READ, a, 0, 1, d0);
        $display("test supply loss done");
        results();
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge MCLK);
        error_cnt++;
        results();
    end
endmodule // nvsram_store_recall_control_tb_top
`default_nettype wire
